// [core/gpcde_pkg.sv]
package gpcde_pkg;
  typedef struct packed
  {
    logic [7:0] out;
    logic [7:0] oe;
  } gpcde_pin_drive_type;

  typedef struct packed
  {
    logic       spi_sck_out;
    logic       spi_mosi_out;
    logic       spi_miso_out;
    logic       uart_tx;
    logic [1:0] tch_out;
  } gpcde_periph_out_type;

  typedef struct packed
  {
    logic       spi_sck_in;
    logic       spi_mosi_in;
    logic       spi_miso_in;
    logic       spi_ss_in;
    logic       uart_rx;
    logic [1:0] tch_in;
    logic       timer_a_ext_clock;
    logic       timer_b_ext_clock;
  } gpcde_periph_in_type;
endpackage

// [core/gpcde_regs.svh]
`ifndef GPCDE_REGS_SVH
`define GPCDE_REGS_SVH
// Printed offsets are not all multiples of four: they are indices, byte address = 4 * index
`define GPCDE_IDX_C_DATA   8'h02
`define GPCDE_IDX_D_DATA   8'h03
`define GPCDE_IDX_C_DIR    8'h04
`define GPCDE_IDX_D_DIR    8'h05
`define GPCDE_IDX_D_PULLUP 8'h06
`define GPCDE_IDX_E_DIR    8'h07
`define GPCDE_IDX_E_DATA   8'h08
`define GPCDE_IDX_SEL      8'h09
`define GPCDE_C_WIDTH      6
`define GPCDE_CLKOUT_BIT   7
`define GPCDE_CLKOUT_PIN   2
`define GPCDE_PS_EXT       3'h7
`define GPCDE_TA_CLK_PIN   6
`define GPCDE_TB_CLK_PIN   4
`define GPCDE_SEL_SPI_EN   0
`define GPCDE_SEL_SPI_MST  1
`define GPCDE_SEL_UART_EN  2
`define GPCDE_SEL_CH0_LO   3
`define GPCDE_SEL_CH1_LO   5
`define GPCDE_SEL_TA_PS_LO 8
`define GPCDE_SEL_TB_PS_LO 11
`define GPCDE_SEL_WIDTH    14
`define GPCDE_SEL_RESET    14'h0000
`endif

// [core/gpcde_top.sv]
// Implementation choice: register access over APB.
`timescale 1ns/1ps
`include "gpcde_regs.svh"
// Function
// [RL1] Port C latch is software read/write and keeps its value through reset.
// [RL2] Setting the clock output enable drives the system clock on port C bit 2.
// [RL3] Clock output enable is read/write, reset clears it; 0 leaves ordinary I/O.
// [RL4] Port C direction bit 1 enables output, 0 input; reset clears all six.
// [RL5] Port C data read gives latch for outputs, synchronised pin for inputs.
// [RL6] Data writes always update the latch; input pins still read the pin.
// [RL7] Software writes the latch before turning a pin into an output.
// [RL8] Port D bit 6 clocks timer A when its prescaler select is all ones.
// [RL9] Port D bit 4 clocks timer B when its prescaler select is all ones.
// [RL10] Port D data read gives latch for outputs and pin level for inputs.
// [RL11] Port D direction bits read/write, 1 output, cleared by reset.
// [RL12] Port D pullup enable connects a pullup, only while the pin is input.
// [RL13] A port D pullup is forced off while its pin is an output.
// [RL14] Port E latch is software read/write and keeps its value through reset.
// [RL15] Port E bit 7 is SPI clock, in as slave, out as master, when SPI on.
// [RL16] Port E bit 6 is SPI MOSI while SPI is enabled, else general I/O.
// [RL17] Port E bit 5 is SPI MISO while SPI is enabled, else general I/O.
// [RL18] Port E bit 4 is slave select unless SPI is off or in master mode.
// [RL19] In SPI slave mode the bit 4 direction bit has no effect on the pin.
// [RL20] Port E bits 3 and 2 are timer channels when edge/level select nonzero.
// [RL21] Port E bit 1 feeds UART receive while the UART is enabled.
// [RL22] Port E bit 0 carries UART transmit while the UART is enabled.
// [RL23] Port E direction bits choose latch or pin on reads, even for peripheral pins.
// [RL24] Pin levels pass a two-stage synchroniser before any read.
module gpcde_top
  import gpcde_pkg::*;
(
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 sys_clock,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  input  wire logic [3:0]           pstrb,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic [7:0]           port_c_pin_in,
  input  wire logic [7:0]           port_d_pin_in,
  input  wire logic [7:0]           port_e_pin_in,
  output gpcde_pin_drive_type       port_c_drive,
  output gpcde_pin_drive_type       port_d_drive,
  output gpcde_pin_drive_type       port_e_drive,
  output logic      [7:0]           port_d_pullup_on,
  input  wire gpcde_periph_out_type periph_out,
  output gpcde_periph_in_type       periph_in,
  output logic      [2:0]           timer_a_prescaler_select,
  output logic      [2:0]           timer_b_prescaler_select
);
  localparam int CW = `GPCDE_C_WIDTH;

  logic [CW-1:0] port_c_latch;
  logic [CW-1:0] port_c_dir;
  logic          sys_clock_out_en;
  logic [7:0]    port_d_latch;
  logic [7:0]    port_d_dir;
  logic [7:0]    port_d_pullup_en;
  logic [7:0]    port_e_latch;
  logic [7:0]    port_e_dir;
  logic [`GPCDE_SEL_WIDTH-1:0] sel_reg;
  logic [7:0]    sync_c1;
  logic [7:0]    sync_c2;
  logic [7:0]    sync_d1;
  logic [7:0]    sync_d2;
  logic [7:0]    sync_e1;
  logic [7:0]    sync_e2;
  logic [9:0]    word_idx;
  logic          wr_en;
  logic          rd_en;
  logic          addr_hit;
  logic [31:0]   next_prdata;
  logic          spi_enable_bit;
  logic          spi_master_select;
  logic          uart_enable_bit;
  logic [1:0]    edge_level_select0;
  logic [1:0]    edge_level_select1;
  logic [7:0]    e_periph_own;
  logic [7:0]    e_periph_oe;
  logic [7:0]    e_periph_val;

  assign word_idx = paddr[11:2];
  assign wr_en    = psel && penable && pwrite;
  assign rd_en    = psel && !penable && !pwrite;
  assign pready   = 1'b1;

  always_comb
  begin
    case (word_idx)
      10'(`GPCDE_IDX_C_DATA), 10'(`GPCDE_IDX_D_DATA), 10'(`GPCDE_IDX_C_DIR),
      10'(`GPCDE_IDX_D_DIR), 10'(`GPCDE_IDX_D_PULLUP), 10'(`GPCDE_IDX_E_DIR),
      10'(`GPCDE_IDX_E_DATA), 10'(`GPCDE_IDX_SEL): addr_hit = 1'b1;
      default: addr_hit = 1'b0;
    endcase
  end

  // Unmapped addresses answer with an error and read as zero
  assign pslverr = psel && penable && !addr_hit;

  // Two flops per pin; only the second stage feeds any logic
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync_c1 <= 8'h00;
      sync_c2 <= 8'h00;
      sync_d1 <= 8'h00;
      sync_d2 <= 8'h00;
      sync_e1 <= 8'h00;
      sync_e2 <= 8'h00;
    end
    else
    begin
      sync_c1 <= port_c_pin_in; // RL24
      sync_c2 <= sync_c1;
      sync_d1 <= port_d_pin_in;
      sync_d2 <= sync_d1;
      sync_e1 <= port_e_pin_in;
      sync_e2 <= sync_e1;
    end
  end

  // Data latches have no reset: their contents survive a reset
  always_ff @(posedge pclk)
  begin
    if (wr_en && pstrb[0])
    begin
      if (word_idx == 10'(`GPCDE_IDX_C_DATA))
        port_c_latch <= pwdata[CW-1:0]; // RL1 RL6
      if (word_idx == 10'(`GPCDE_IDX_D_DATA))
        port_d_latch <= pwdata[7:0]; // RL6
      if (word_idx == 10'(`GPCDE_IDX_E_DATA))
        port_e_latch <= pwdata[7:0]; // RL14 RL6
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      port_c_dir       <= '0; // RL4
      sys_clock_out_en <= 1'b0; // RL3
      port_d_dir       <= 8'h00; // RL11
      port_d_pullup_en <= 8'h00;
      port_e_dir       <= 8'h00;
    end
    else if (wr_en && pstrb[0])
    begin
      if (word_idx == 10'(`GPCDE_IDX_C_DIR))
      begin
        port_c_dir       <= pwdata[CW-1:0]; // RL4
        sys_clock_out_en <= pwdata[`GPCDE_CLKOUT_BIT]; // RL3
      end
      if (word_idx == 10'(`GPCDE_IDX_D_DIR))
        port_d_dir <= pwdata[7:0]; // RL11
      if (word_idx == 10'(`GPCDE_IDX_D_PULLUP))
        port_d_pullup_en <= pwdata[7:0]; // RL12
      if (word_idx == 10'(`GPCDE_IDX_E_DIR))
        port_e_dir <= pwdata[7:0];
    end
  end

  // Mirror of the peripheral control fields that steer pin ownership
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sel_reg <= `GPCDE_SEL_RESET;
    else if (wr_en && word_idx == 10'(`GPCDE_IDX_SEL))
    begin
      if (pstrb[0])
        sel_reg[7:0] <= pwdata[7:0];
      if (pstrb[1])
        sel_reg[`GPCDE_SEL_WIDTH-1:8] <= pwdata[`GPCDE_SEL_WIDTH-1:8];
    end
  end

  assign spi_enable_bit     = sel_reg[`GPCDE_SEL_SPI_EN];
  assign spi_master_select  = sel_reg[`GPCDE_SEL_SPI_MST];
  assign uart_enable_bit    = sel_reg[`GPCDE_SEL_UART_EN];
  assign edge_level_select0 = sel_reg[`GPCDE_SEL_CH0_LO +: 2];
  assign edge_level_select1 = sel_reg[`GPCDE_SEL_CH1_LO +: 2];
  assign timer_a_prescaler_select = sel_reg[`GPCDE_SEL_TA_PS_LO +: 3];
  assign timer_b_prescaler_select = sel_reg[`GPCDE_SEL_TB_PS_LO +: 3];

  // Port C: bit 2 may carry the system clock instead of the latch
  always_comb
  begin
    port_c_drive = '0;
    port_c_drive.out[CW-1:0] = port_c_latch;
    port_c_drive.oe[CW-1:0]  = port_c_dir; // RL4
    if (sys_clock_out_en)
    begin
      port_c_drive.out[`GPCDE_CLKOUT_PIN] = sys_clock; // RL2
      port_c_drive.oe[`GPCDE_CLKOUT_PIN]  = 1'b1; // RL2
    end
  end

  assign port_d_drive.out = port_d_latch;
  assign port_d_drive.oe  = port_d_dir;
  // Pullup dies as soon as the pin turns output, not on the next write
  assign port_d_pullup_on = port_d_pullup_en & ~port_d_dir; // RL12 RL13

  // Port E ownership: peripheral pins ignore the direction register for drive, not for reads
  always_comb
  begin
    e_periph_own = 8'h00;
    e_periph_oe  = 8'h00;
    e_periph_val = 8'h00;
    e_periph_own[7] = spi_enable_bit; // RL15
    e_periph_oe[7]  = spi_master_select;
    e_periph_val[7] = periph_out.spi_sck_out;
    e_periph_own[6] = spi_enable_bit; // RL16
    e_periph_oe[6]  = spi_master_select;
    e_periph_val[6] = periph_out.spi_mosi_out;
    e_periph_own[5] = spi_enable_bit; // RL17
    e_periph_oe[5]  = !spi_master_select;
    e_periph_val[5] = periph_out.spi_miso_out;
    e_periph_own[4] = spi_enable_bit && !spi_master_select; // RL18 RL19
    e_periph_oe[4]  = 1'b0;
    e_periph_own[3] = edge_level_select1 != 2'h0; // RL20
    e_periph_oe[3]  = 1'b1;
    e_periph_val[3] = periph_out.tch_out[1];
    e_periph_own[2] = edge_level_select0 != 2'h0; // RL20
    e_periph_oe[2]  = 1'b1;
    e_periph_val[2] = periph_out.tch_out[0];
    e_periph_own[1] = uart_enable_bit; // RL21
    e_periph_oe[1]  = 1'b0;
    e_periph_own[0] = uart_enable_bit; // RL22
    e_periph_oe[0]  = 1'b1;
    e_periph_val[0] = periph_out.uart_tx;
  end

  assign port_e_drive.oe  = (e_periph_own & e_periph_oe) | (~e_periph_own & port_e_dir);
  assign port_e_drive.out = (e_periph_own & e_periph_val) | (~e_periph_own & port_e_latch);

  // Peripheral inputs use synchronised levels; slave select and UART receive read idle when their pin is not owned
  always_comb
  begin
    periph_in = '0;
    periph_in.spi_sck_in  = sync_e2[7];
    periph_in.spi_mosi_in = sync_e2[6];
    periph_in.spi_miso_in = sync_e2[5];
    periph_in.spi_ss_in   = e_periph_own[4] ? sync_e2[4] : 1'b1; // RL18
    periph_in.uart_rx     = uart_enable_bit ? sync_e2[1] : 1'b1; // RL21
    periph_in.tch_in      = sync_e2[3:2];
    periph_in.timer_a_ext_clock = (timer_a_prescaler_select == `GPCDE_PS_EXT)
                                  && sync_d2[`GPCDE_TA_CLK_PIN]; // RL8
    periph_in.timer_b_ext_clock = (timer_b_prescaler_select == `GPCDE_PS_EXT)
                                  && sync_d2[`GPCDE_TB_CLK_PIN]; // RL9
  end

  always_comb
  begin
    next_prdata = 32'h0000_0000;
    case (word_idx)
      10'(`GPCDE_IDX_C_DATA):
        next_prdata[CW-1:0] = (port_c_dir & port_c_latch)
                              | (~port_c_dir & sync_c2[CW-1:0]); // RL5
      10'(`GPCDE_IDX_D_DATA):
        next_prdata[7:0] = (port_d_dir & port_d_latch) | (~port_d_dir & sync_d2); // RL10
      10'(`GPCDE_IDX_E_DATA):
        next_prdata[7:0] = (port_e_dir & port_e_latch) | (~port_e_dir & sync_e2); // RL23
      10'(`GPCDE_IDX_C_DIR):
      begin
        next_prdata[CW-1:0] = port_c_dir;
        next_prdata[`GPCDE_CLKOUT_BIT] = sys_clock_out_en;
      end
      10'(`GPCDE_IDX_D_DIR):    next_prdata[7:0] = port_d_dir;
      10'(`GPCDE_IDX_D_PULLUP): next_prdata[7:0] = port_d_pullup_en;
      10'(`GPCDE_IDX_E_DIR):    next_prdata[7:0] = port_e_dir;
      10'(`GPCDE_IDX_SEL):      next_prdata[`GPCDE_SEL_WIDTH-1:0] = sel_reg;
      default:                  next_prdata = 32'h0000_0000;
    endcase
  end

  // Read data captured in setup phase, valid through the zero-wait access phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (rd_en)
      prdata <= next_prdata;
  end

  property p_dir_c_reset;
    @(posedge pclk) $rose(presetn) |-> port_c_dir == '0 && !sys_clock_out_en;
  endproperty
  a_dir_c_reset: assert property (p_dir_c_reset) else $error("port C dir not cleared"); // RL4

  property p_clkout;
    @(posedge pclk) disable iff (!presetn)
      sys_clock_out_en |-> port_c_drive.oe[`GPCDE_CLKOUT_PIN];
  endproperty
  a_clkout: assert property (p_clkout) else $error("clock pin not driven"); // RL2

  property p_clken_write;
    @(posedge pclk) disable iff (!presetn)
      wr_en && pstrb[0] && word_idx == 10'(`GPCDE_IDX_C_DIR)
      |=> sys_clock_out_en == $past(pwdata[`GPCDE_CLKOUT_BIT]);
  endproperty
  a_clken_write: assert property (p_clken_write) else $error("clock enable not written"); // RL3

  property p_c_read;
    @(posedge pclk) disable iff (!presetn)
      rd_en && word_idx == 10'(`GPCDE_IDX_C_DATA) && port_c_dir == '0
      |=> prdata[CW-1:0] == $past(sync_c2[CW-1:0]);
  endproperty
  a_c_read: assert property (p_c_read) else $error("port C input read wrong"); // RL5

  property p_latch_write;
    @(posedge pclk) disable iff (!presetn)
      wr_en && pstrb[0] && word_idx == 10'(`GPCDE_IDX_D_DATA)
      |=> port_d_latch == $past(pwdata[7:0]);
  endproperty
  a_latch_write: assert property (p_latch_write) else $error("latch not written"); // RL6

  property p_pullup_off;
    @(posedge pclk) disable iff (!presetn) (port_d_pullup_on & port_d_dir) == 8'h00;
  endproperty
  a_pullup_off: assert property (p_pullup_off) else $error("pullup on output"); // RL13

  property p_d_read;
    @(posedge pclk) disable iff (!presetn)
      rd_en && word_idx == 10'(`GPCDE_IDX_D_DATA) && port_d_dir == 8'hff
      |=> prdata[7:0] == $past(port_d_latch);
  endproperty
  a_d_read: assert property (p_d_read) else $error("port D output read wrong"); // RL10

  property p_uart_tx;
    @(posedge pclk) disable iff (!presetn)
      uart_enable_bit |-> port_e_drive.oe[0] && port_e_drive.out[0] == periph_out.uart_tx;
  endproperty
  a_uart_tx: assert property (p_uart_tx) else $error("uart tx not on pin"); // RL22

  property p_ss_in;
    @(posedge pclk) disable iff (!presetn)
      spi_enable_bit && !spi_master_select |-> !port_e_drive.oe[4];
  endproperty
  a_ss_in: assert property (p_ss_in) else $error("slave select driven"); // RL19

  property p_timer_a_ext_clock;
    @(posedge pclk) disable iff (!presetn)
      timer_a_prescaler_select != `GPCDE_PS_EXT |-> !periph_in.timer_a_ext_clock;
  endproperty
  a_timer_a_ext_clock: assert property (p_timer_a_ext_clock) else $error("timer A clock leaked"); // RL8

  property p_timer_b_ext_clock;
    @(posedge pclk) disable iff (!presetn)
      timer_b_prescaler_select != `GPCDE_PS_EXT |-> !periph_in.timer_b_ext_clock;
  endproperty
  a_timer_b_ext_clock: assert property (p_timer_b_ext_clock) else $error("timer B clock leaked"); // RL9

  property p_e_read;
    @(posedge pclk) disable iff (!presetn)
      rd_en && word_idx == 10'(`GPCDE_IDX_E_DATA) && port_e_dir == 8'hff
      |=> prdata[7:0] == $past(port_e_latch);
  endproperty
  a_e_read: assert property (p_e_read) else $error("port E output read wrong"); // RL23

  property p_miso_slave;
    @(posedge pclk) disable iff (!presetn)
      spi_enable_bit && !spi_master_select
      |-> port_e_drive.oe[5] && port_e_drive.out[5] == periph_out.spi_miso_out;
  endproperty
  a_miso_slave: assert property (p_miso_slave) else $error("slave data out missing"); // RL17

  property p_sck_master;
    @(posedge pclk) disable iff (!presetn)
      spi_enable_bit && spi_master_select
      |-> port_e_drive.oe[7] && port_e_drive.out[7] == periph_out.spi_sck_out;
  endproperty
  a_sck_master: assert property (p_sck_master) else $error("serial clock not driven"); // RL15

  property p_rx_idle;
    @(posedge pclk) disable iff (!presetn)
      !uart_enable_bit |-> periph_in.uart_rx;
  endproperty
  a_rx_idle: assert property (p_rx_idle) else $error("uart rx not idle"); // RL21

  property p_c_clk_off;
    @(posedge pclk) disable iff (!presetn)
      !sys_clock_out_en |-> port_c_drive.oe[CW-1:0] == port_c_dir;
  endproperty
  a_c_clk_off: assert property (p_c_clk_off) else $error("clock pin not plain I/O"); // RL3
endmodule

// [dv/gpcde_pin_model.sv]
`timescale 1ns/1ps
module gpcde_pin_model
  import gpcde_pkg::*;
(
  input  wire logic                pclk,
  input  wire gpcde_pin_drive_type c_drv,
  input  wire gpcde_pin_drive_type d_drv,
  input  wire gpcde_pin_drive_type e_drv,
  input  wire logic [7:0]          d_pull,
  input  wire logic [23:0]         ext_val,
  input  wire logic [23:0]         ext_oe,
  output logic      [23:0]         pins
);
  logic        flt = 1'b0;
  logic [23:0] oe;
  logic [23:0] out;
  logic [23:0] pu;

  assign oe  = {e_drv.oe, d_drv.oe, c_drv.oe};
  assign out = {e_drv.out, d_drv.out, c_drv.out};
  assign pu  = {8'h00, d_pull, 8'h00};

  // A floating pin wanders so that a stale level never reads as valid
  always @(posedge pclk)
    flt <= ~flt;

  always_comb
    for (int i = 0; i < 24; i++)
    begin
      pins[i] = oe[i] ? out[i] : ext_oe[i] ? ext_val[i] : pu[i] ? 1'b1 : flt ^ i[0];
    end
endmodule

// [dv/tb_gpio_ports_c_d_e.sv]
`timescale 1ns/1ps
`include "gpcde_regs.svh"
module tb_gpio_ports_c_d_e
  import gpcde_pkg::*;
  ;
  typedef struct packed
  {
    logic [7:0]  idx;
    logic [31:0] d;
    logic [31:0] exp;
  } gpcde_tb_row_type;

  logic                 pclk      = 1'b0;
  logic                 presetn   = 1'b0;
  logic                 sys_clock = 1'b0;
  logic                 psel      = 1'b0;
  logic                 penable   = 1'b0;
  logic                 pwrite    = 1'b0;
  logic [11:0]          paddr     = 12'h000;
  logic [31:0]          pwdata    = 32'h0;
  logic [31:0]          prdata;
  logic                 pready;
  logic                 pslverr;
  logic [23:0]          ext_val   = 24'h005015;
  logic [23:0]          ext_oe    = 24'hffff3f;
  logic [23:0]          pins;
  gpcde_pin_drive_type  c_drv;
  gpcde_pin_drive_type  d_drv;
  gpcde_pin_drive_type  e_drv;
  logic [7:0]           d_pull;
  gpcde_periph_out_type pout      = 6'h2a;
  gpcde_periph_in_type  pin_i;
  logic [2:0]           ps_a;
  logic [2:0]           ps_b;
  logic [31:0]          rd;
  logic                 err;
  int                   bad_count = 0;
  int                   tests_run = 0;
  gpcde_tb_row_type     rows [6]  = '{
    '{`GPCDE_IDX_C_DIR, 32'h3f, 32'h3f}, '{`GPCDE_IDX_D_DIR, 32'ha5, 32'ha5},
    '{`GPCDE_IDX_D_PULLUP, 32'h5a, 32'h5a}, '{`GPCDE_IDX_E_DIR, 32'h3c, 32'h3c},
    '{`GPCDE_IDX_SEL, 32'h3f00, 32'h3f00}, '{`GPCDE_IDX_D_DIR, 32'h00, 32'h00}};

  initial
    forever #5 pclk = ~pclk;

  always @(posedge pclk)
    sys_clock <= ~sys_clock;

  gpcde_top gpcde_top_inst (.pclk(pclk), .presetn(presetn), .sys_clock(sys_clock),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .port_c_pin_in(pins[7:0]), .port_d_pin_in(pins[15:8]), .port_e_pin_in(pins[23:16]),
    .port_c_drive(c_drv), .port_d_drive(d_drv), .port_e_drive(e_drv),
    .port_d_pullup_on(d_pull), .periph_out(pout), .periph_in(pin_i),
    .timer_a_prescaler_select(ps_a), .timer_b_prescaler_select(ps_b));

  gpcde_pin_model gpcde_pin_model_inst (.pclk(pclk), .c_drv(c_drv), .d_drv(d_drv),
    .e_drv(e_drv), .d_pull(d_pull), .ext_val(ext_val), .ext_oe(ext_oe), .pins(pins));

  task automatic finish_test;
    $display("Counts: %0d compares, %0d mismatches", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    tests_run++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // Holds the request until pready is seen high at a rising edge
  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {2'b00, idx, 2'b00};
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge pclk);
      n++;
    end
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 20)
    begin
      bad_count++;
      $display("[ERR] %0t bus answer timeout", $time);
      finish_test();
    end
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    xfer(1'b1, idx, d);
  endtask

  task automatic rdc(input logic [7:0] idx, input logic [31:0] exp, input string m);
    xfer(1'b0, idx, 32'h0);
    chk(rd, exp, m);
  endtask

  initial
  begin
    cyc(6);
    presetn <= 1'b1;
    rdc(`GPCDE_IDX_C_DIR, 32'h0, "c dir reset");
    rdc(`GPCDE_IDX_D_DIR, 32'h0, "d dir reset");
    rdc(`GPCDE_IDX_E_DIR, 32'h0, "e dir reset");
    rdc(`GPCDE_IDX_D_PULLUP, 32'h0, "pullup reset");
    $display("test reset done");
    foreach (rows[i])
    begin
      wr(rows[i].idx, rows[i].d);
      rdc(rows[i].idx, rows[i].exp, "readback");
    end
    cyc(4);
    chk({ps_a, ps_b}, 6'h3f, "prescaler mirror");
    chk({pin_i.timer_a_ext_clock, pin_i.timer_b_ext_clock}, 2'b11, "ext clk hi");
    ext_val[15:8] <= 8'h00;
    cyc(4);
    chk({pin_i.timer_a_ext_clock, pin_i.timer_b_ext_clock}, 2'b00, "ext clk lo");
    ext_val[15:8] <= 8'h50;
    wr(`GPCDE_IDX_SEL, 32'h3600);
    cyc(4);
    chk({pin_i.timer_a_ext_clock, pin_i.timer_b_ext_clock}, 2'b00, "ext clk off");
    $display("test table and timers done");
    wr(`GPCDE_IDX_C_DIR, 32'h00);
    wr(`GPCDE_IDX_C_DATA, 32'h2a);
    rdc(`GPCDE_IDX_C_DATA, 32'h15, "c input read");
    wr(`GPCDE_IDX_C_DIR, 32'h0b);
    rdc(`GPCDE_IDX_C_DATA, 32'h1e, "c mixed read");
    chk(c_drv.oe, 8'h0b, "c oe");
    chk(c_drv.out & 8'h0b, 8'h0a, "c out");
    wr(`GPCDE_IDX_C_DIR, 32'h8b);
    rdc(`GPCDE_IDX_C_DIR, 32'h8b, "clk en read");
    repeat (3)
    begin
      @(negedge pclk);
      chk({c_drv.oe[2], c_drv.out[2]}, {1'b1, sys_clock}, "clk out");
    end
    wr(`GPCDE_IDX_C_DIR, 32'h0b);
    // The write lands at the edge that ends the task; look once it has settled
    @(negedge pclk);
    chk(c_drv.oe[2], 1'b0, "clk off");
    $display("test port c done");
    wr(`GPCDE_IDX_D_DATA, 32'h66);
    wr(`GPCDE_IDX_D_PULLUP, 32'hff);
    wr(`GPCDE_IDX_D_DIR, 32'hf0);
    ext_oe[15:8] <= 8'h00;
    cyc(4);
    chk(d_pull, 8'h0f, "pullup gate");
    chk(d_drv.oe, 8'hf0, "d oe");
    chk(d_drv.out, 8'h66, "d out");
    rdc(`GPCDE_IDX_D_DATA, 32'h6f, "d read");
    $display("test port d done");
    wr(`GPCDE_IDX_E_DATA, 32'hc3);
    presetn <= 1'b0;
    cyc(6);
    presetn <= 1'b1;
    wr(`GPCDE_IDX_E_DIR, 32'hff);
    wr(`GPCDE_IDX_C_DIR, 32'h3f);
    rdc(`GPCDE_IDX_E_DATA, 32'hc3, "e latch kept");
    rdc(`GPCDE_IDX_C_DATA, 32'h2a, "c latch kept");
    $display("test latch through reset done");
    wr(`GPCDE_IDX_E_DIR, 32'h00);
    wr(`GPCDE_IDX_SEL, 32'h07);
    @(negedge pclk);
    chk(e_drv.oe, 8'hc1, "master oe");
    chk(e_drv.out & 8'hc1, 8'h80, "master out");
    wr(`GPCDE_IDX_E_DIR, 32'hff);
    rdc(`GPCDE_IDX_E_DATA, 32'hc3, "e owned read");
    wr(`GPCDE_IDX_E_DIR, 32'h10);
    wr(`GPCDE_IDX_SEL, 32'h2d);
    cyc(4);
    chk(e_drv.oe, 8'h2d, "slave oe");
    chk(e_drv.out & 8'h2d, 8'h28, "slave out");
    chk({pin_i.uart_rx, pin_i.spi_ss_in}, 2'b00, "rx ss owned");
    chk({pin_i.spi_sck_in, pin_i.spi_mosi_in, pin_i.spi_miso_in, pin_i.tch_in}, 5'b00110,
        "slave in");
    wr(`GPCDE_IDX_SEL, 32'h00);
    cyc(4);
    chk(e_drv.oe, 8'h10, "e gpio oe");
    chk({pin_i.uart_rx, pin_i.spi_ss_in}, 2'b11, "rx ss free");
    $display("test port e done");
    xfer(1'b0, 8'h3f, 32'h0);
    chk({err, rd}, {1'b1, 32'h0}, "unmapped");
    $display("test unmapped done");
    finish_test();
  end
endmodule
